/* dscp_priority_and_snoop_ctrl.sv */
`timescale 1ns/10ps
// ****************************************************************
// dscp priority map and global snoop/mirror control
// ****************************************************************

// Behaviour
// R1: codes 0x2A/0x2B use bits 2:0/6:4, reset zero
// R2: codes 0x2C/0x2D use low/high field
// R3: codes 0x2E/0x2F use low/high field
// R4: codes 0x30/0x31 use low/high field
// R5: codes 0x32/0x33 use low/high field
// R6: codes 0x34/0x35 use low/high field
// R7: codes 0x36/0x37 use low/high field
// R8: codes 0x38/0x39 use low/high field
// R9: codes 0x3A/0x3B use low/high field
// R10: codes 0x3C/0x3D use low/high field
// R11: codes 0x3E/0x3F use low/high field
// R12: group snoop bit sends IGMP to host
// R13: listener snoop bit sends MLD to host
// R14: criteria clear: next header 1 or 58
// R15: criteria set: next header 43,44,50,51,60
// R16: filter select one: source and destination match
// R17: filter select zero: source or destination match
// R18: software must also program per-port mirroring
module dscp_priority_and_snoop_ctrl
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_ff,
   output logic reg_ack_ff,
   input wire logic frame_valid,
   input wire dscp_snoop_pkg::frame_info_type frame_info,
   output logic verdict_valid_ff,
   output dscp_snoop_pkg::verdict_type verdict_ff
);

   // ****************************************************************
   // storage
   // ****************************************************************
   // two 3-bit fields per mapping register, high field on top
   logic [dscp_snoop_pkg::MAP_COUNT-1:0][5:0] map_ff;
   // global control bits
   dscp_snoop_pkg::ctrl_type ctrl_ff;

   // ****************************************************************
   // address decode
   // ****************************************************************
   // one-hot hit per mapping register
   logic [dscp_snoop_pkg::MAP_COUNT-1:0] map_sel;
   // control register hit
   wire ctrl_sel = reg_addr == dscp_snoop_pkg::CTRL_ADDR;
   // any mapped register hit
   wire any_sel = ctrl_sel | (|map_sel);

   // compare the address against each mapping offset
   genvar gi;
   generate
      for (gi = 0; gi < dscp_snoop_pkg::MAP_COUNT; gi++)
      begin : g_dec
         assign map_sel[gi] = reg_addr == dscp_snoop_pkg::MAP_ADDR[gi];
      end
   endgenerate

   // ****************************************************************
   // write data shaping
   // ****************************************************************
   // priority fields taken from the written byte
   wire [2:0] wr_lo = reg_wdata[dscp_snoop_pkg::LO_LSB +: 3];
   wire [2:0] wr_hi = reg_wdata[dscp_snoop_pkg::HI_LSB +: 3];
   // control fields taken from the written byte
   dscp_snoop_pkg::ctrl_type wr_ctrl;
   assign wr_ctrl.group_snoop_enable =
      reg_wdata[dscp_snoop_pkg::GROUP_EN_BIT];
   assign wr_ctrl.listener_snoop_criteria_select =
      reg_wdata[dscp_snoop_pkg::CRIT_BIT];
   assign wr_ctrl.listener_snoop_enable =
      reg_wdata[dscp_snoop_pkg::LISTEN_EN_BIT];
   assign wr_ctrl.mirror_and_mode =
      reg_wdata[dscp_snoop_pkg::MIRROR_AND_BIT];

   // ****************************************************************
   // read data shaping
   // ****************************************************************
   // selected mapping contents, zero when none hits
   logic [5:0] map_rd;
   always_comb
   begin
      map_rd = 6'h00;
      for (int i = 0; i < dscp_snoop_pkg::MAP_COUNT; i++)
      begin
         // one-hot select, so or-ing is exact
         if (map_sel[i])
         begin
            map_rd = map_rd | map_ff[i];
         end
      end
   end

   // mapping byte with reserved bits 7 and 3 as zero
   wire [7:0] map_byte = {1'b0, map_rd[5:3], 1'b0, map_rd[2:0]};
   // control byte with reserved bits 7, 5, 4, 1 as zero
   wire [7:0] ctrl_byte = {1'b0, ctrl_ff.group_snoop_enable, 2'b00,
                           ctrl_ff.listener_snoop_criteria_select,
                           ctrl_ff.listener_snoop_enable, 1'b0,
                           ctrl_ff.mirror_and_mode};
   // unmapped addresses read as zero
   wire [7:0] nxt_rdata = ctrl_sel ? ctrl_byte :
                          (|map_sel) ? map_byte : 8'h00;
   // every access is acknowledged, mapped or not
   wire nxt_ack = reg_wr_en | reg_rd_en;

   // ****************************************************************
   // register write
   // ****************************************************************
   // mapping registers, cleared to zero at reset
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         map_ff <= {dscp_snoop_pkg::MAP_COUNT{dscp_snoop_pkg::MAP_RESET}};
      end
      else
      begin
         for (int i = 0; i < dscp_snoop_pkg::MAP_COUNT; i++)
         begin
            // store both fields of the addressed pair
            if (reg_wr_en && map_sel[i])
            begin
               map_ff[i] <= {wr_hi, wr_lo}; // R1
            end
         end
      end
   end

   // control register, all features off at reset
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl_ff <= '0;
      end
      else if (reg_wr_en && ctrl_sel)
      begin
         ctrl_ff <= wr_ctrl; // R12 R13
      end
   end

   // ****************************************************************
   // register read and acknowledge
   // ****************************************************************
   // read data lands one cycle after the access
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         reg_rdata_ff <= dscp_snoop_pkg::RDATA_RESET;
         reg_ack_ff <= 1'b0;
      end
      else
      begin
         reg_ack_ff <= nxt_ack;
         // hold the last read value between reads
         if (reg_rd_en)
         begin
            reg_rdata_ff <= nxt_rdata;
         end
      end
   end

   // ****************************************************************
   // frame classification
   // ****************************************************************
   // combined verdict for the frame on the inputs
   dscp_snoop_pkg::verdict_type nxt_verdict;

   // priority from the dscp map
   dscp_prio_lookup u_lookup
   (
      .map(map_ff),
      .is_ip(frame_info.is_ipv4 | frame_info.is_ipv6),
      .dscp(frame_info.dscp),
      .hit(nxt_verdict.prio_hit),
      .prio(nxt_verdict.prio)
   );

   // snooping and mirror decisions; port matches arrive already
   // gated by per-port ingress mirroring settings
   snoop_mirror_filter u_filter
   (
      .ctrl(ctrl_ff),
      .info(frame_info),
      .to_host(nxt_verdict.to_host),
      .mirror(nxt_verdict.mirror)
   );

   // ****************************************************************
   // verdict register
   // ****************************************************************
   // verdict valid one cycle after the frame facts
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         verdict_valid_ff <= 1'b0;
         verdict_ff <= '0;
      end
      else
      begin
         verdict_valid_ff <= frame_valid;
         // keep the last verdict when no frame is offered
         if (frame_valid)
         begin
            verdict_ff <= nxt_verdict;
         end
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // ipv4 or ipv6 frame offered
   wire ip_frame = frame_valid & (frame_info.is_ipv4 | frame_info.is_ipv6);

   a_map_2a_low: assert property ( // R1
      ip_frame && frame_info.dscp == 6'h2A
      |=> verdict_ff.prio_hit && verdict_ff.prio == $past(map_ff[0][2:0]))
      else $error("code 0x2A priority wrong");

   a_map_2b_high: assert property ( // R1
      ip_frame && frame_info.dscp == 6'h2B
      |=> verdict_ff.prio == $past(map_ff[0][5:3]))
      else $error("code 0x2B priority wrong");

   a_map_2d_high: assert property ( // R2
      ip_frame && frame_info.dscp == 6'h2D
      |=> verdict_ff.prio == $past(map_ff[1][5:3]))
      else $error("code 0x2D priority wrong");

   a_map_3e_low: assert property ( // R11
      ip_frame && frame_info.dscp == 6'h3E
      |=> verdict_ff.prio == $past(map_ff[10][2:0]))
      else $error("code 0x3E priority wrong");

   a_map_write_read: assert property ( // R6
      reg_wr_en && reg_addr == 16'h035A ##1 reg_rd_en && !reg_wr_en
      && reg_addr == 16'h035A
      |=> reg_rdata_ff == ($past(reg_wdata, 2) & 8'h77))
      else $error("code 0x34 register readback wrong");

   a_igmp_host: assert property ( // R12
      frame_valid && frame_info.is_ipv4 && frame_info.is_igmp
      && !frame_info.is_ipv6
      |=> verdict_ff.to_host == $past(ctrl_ff.group_snoop_enable))
      else $error("group snooping forward wrong");

   a_mld_off: assert property ( // R13
      frame_valid && frame_info.is_ipv6 && !frame_info.is_ipv4
      && !ctrl_ff.listener_snoop_enable |=> !verdict_ff.to_host)
      else $error("listener snooping forwards while off");

   a_mld_basic: assert property ( // R14
      frame_valid && frame_info.is_ipv6 && ctrl_ff.listener_snoop_enable
      && !ctrl_ff.listener_snoop_criteria_select
      && frame_info.next_hdr == 8'h00 && frame_info.hop_next_hdr == 8'h3A
      |=> verdict_ff.to_host)
      else $error("hop-by-hop 58 not snooped");

   a_mld_ext: assert property ( // R15
      frame_valid && frame_info.is_ipv6 && ctrl_ff.listener_snoop_enable
      && ctrl_ff.listener_snoop_criteria_select
      && frame_info.next_hdr == 8'h3C |=> verdict_ff.to_host)
      else $error("next header 60 not snooped");

   a_mirror_and: assert property ( // R16
      frame_valid && ctrl_ff.mirror_and_mode
      |=> verdict_ff.mirror ==
          ($past(frame_info.src_match) && $past(frame_info.dst_match)))
      else $error("and-mode mirror wrong");

   a_mirror_or: assert property ( // R17
      frame_valid && !ctrl_ff.mirror_and_mode
      |=> verdict_ff.mirror ==
          ($past(frame_info.src_match) || $past(frame_info.dst_match)))
      else $error("or-mode mirror wrong");

   a_low_code_miss: assert property ( // R1
      ip_frame && frame_info.dscp < 6'h2A |=> !verdict_ff.prio_hit)
      else $error("code below range reported as mapped");

   c_map_hit: cover property (ip_frame && frame_info.dscp == 6'h3F
      ##1 verdict_ff.prio != 3'h0);
   c_mld_fwd: cover property (frame_valid && frame_info.is_ipv6
      ##1 verdict_ff.to_host);
   c_mirror_and: cover property (ctrl_ff.mirror_and_mode && frame_valid
      ##1 verdict_ff.mirror);

endmodule // dscp_priority_and_snoop_ctrl

/* dscp_snoop_pkg.sv */
// ****************************************************************
// constants and carriers shared by the priority and snoop block
// ****************************************************************
package dscp_snoop_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   // number of byte-wide dscp mapping registers
   localparam int MAP_COUNT = 11;
   // first dscp code covered by the mapping registers
   localparam logic [5:0] DSCP_FIRST = 6'h2A;
   // mapping register offsets, index 0 serves codes 0x2A/0x2B
   localparam logic [MAP_COUNT-1:0][15:0] MAP_ADDR = {
      16'h035F, 16'h035E, 16'h035D, 16'h035C, 16'h035B, 16'h035A,
      16'h0359, 16'h0358, 16'h0357, 16'h0350, 16'h0355};
   // global mirroring and snooping control offset
   localparam logic [15:0] CTRL_ADDR = 16'h0370;

   // ****************************************************************
   // field layout and reset values
   // ****************************************************************
   localparam int PRIO_W = 3;        // width of one priority field
   localparam int LO_LSB = 0;        // even code field, bits 2:0
   localparam int HI_LSB = 4;        // odd code field, bits 6:4
   localparam int GROUP_EN_BIT = 6;  // ipv4 group snooping enable
   localparam int CRIT_BIT = 3;      // listener criteria select
   localparam int LISTEN_EN_BIT = 2; // ipv6 listener snooping enable
   localparam int MIRROR_AND_BIT = 0; // mirror filter select
   localparam logic [5:0] MAP_RESET = 6'h00;
   localparam logic [7:0] RDATA_RESET = 8'h00;

   // ****************************************************************
   // ipv6 next header codes
   // ****************************************************************
   localparam logic [7:0] NH_HOP = 8'h00;     // hop-by-hop header
   localparam logic [7:0] NH_ICMP = 8'h01;    // 1
   localparam logic [7:0] NH_ICMPV6 = 8'h3A;  // 58
   localparam logic [7:0] NH_ROUTE = 8'h2B;   // 43
   localparam logic [7:0] NH_FRAG = 8'h2C;    // 44
   localparam logic [7:0] NH_ESP = 8'h32;     // 50
   localparam logic [7:0] NH_AUTH = 8'h33;    // 51
   localparam logic [7:0] NH_DEST = 8'h3C;    // 60

   // ****************************************************************
   // carriers
   // ****************************************************************
   // global control bits as stored
   typedef struct packed {
      logic group_snoop_enable;
      logic listener_snoop_criteria_select;
      logic listener_snoop_enable;
      logic mirror_and_mode;
   } ctrl_type;

   // per-frame facts from the parser
   typedef struct packed {
      logic is_ipv4;
      logic is_ipv6;
      logic is_igmp;
      logic [5:0] dscp;
      logic [7:0] next_hdr;
      logic [7:0] hop_next_hdr;
      logic src_match;
      logic dst_match;
   } frame_info_type;

   // per-frame verdict to forwarding
   typedef struct packed {
      logic prio_hit;
      logic [PRIO_W-1:0] prio;
      logic to_host;
      logic mirror;
   } verdict_type;

endpackage

/* dscp_prio_lookup.sv */
`timescale 1ns/10ps
// ****************************************************************
// dscp code to priority lookup
// ****************************************************************
module dscp_prio_lookup
(
   input wire logic [dscp_snoop_pkg::MAP_COUNT-1:0][5:0] map,
   input wire logic is_ip,
   input wire logic [5:0] dscp,
   output logic hit,
   output logic [dscp_snoop_pkg::PRIO_W-1:0] prio
);
   // offset of the code from the first mapped code
   wire [5:0] code_off = dscp - dscp_snoop_pkg::DSCP_FIRST;
   // register index, two codes per register
   wire [3:0] idx = code_off[4:1];
   // codes below the first mapped code are out of range
   wire in_range = dscp >= dscp_snoop_pkg::DSCP_FIRST;
   // selected register contents, zero outside the mapped range
   wire [5:0] pair = in_range ? map[idx] : 6'h00;

   // odd code takes the high field, even code the low one
   // unmapped frames get priority zero, never an unknown
   assign prio = !hit ? 3'h0 :
                 dscp[0] ? pair[5:3] : pair[2:0]; // R1 R2 R3 R4 R5 R6
   // same selection serves the upper half of the range
   assign hit = is_ip & in_range; // R7 R8 R9 R10 R11
endmodule // dscp_prio_lookup

/* snoop_mirror_filter.sv */
`timescale 1ns/10ps
// ****************************************************************
// multicast snooping match and mirror filter
// ****************************************************************
module snoop_mirror_filter
(
   input wire dscp_snoop_pkg::ctrl_type ctrl,
   input wire dscp_snoop_pkg::frame_info_type info,
   output logic to_host,
   output logic mirror
);
   // default listener set: next header 1 or 58
   function automatic logic set_basic(input logic [7:0] nh);
      set_basic = (nh == dscp_snoop_pkg::NH_ICMP) |
                  (nh == dscp_snoop_pkg::NH_ICMPV6);
   endfunction

   // alternate listener set: 43, 44, 50, 51 or 60
   function automatic logic set_ext(input logic [7:0] nh);
      set_ext = (nh == dscp_snoop_pkg::NH_ROUTE) |
                (nh == dscp_snoop_pkg::NH_FRAG) |
                (nh == dscp_snoop_pkg::NH_ESP) |
                (nh == dscp_snoop_pkg::NH_AUTH) |
                (nh == dscp_snoop_pkg::NH_DEST);
   endfunction

   // hop-by-hop header present
   wire via_hop = info.next_hdr == dscp_snoop_pkg::NH_HOP;
   // match on the chosen set, directly or behind hop-by-hop
   wire basic_hit = set_basic(info.next_hdr) |
                    (via_hop & set_basic(info.hop_next_hdr)); // R14
   wire ext_hit = set_ext(info.next_hdr) |
                  (via_hop & set_ext(info.hop_next_hdr)); // R15
   wire listener_pkt = ctrl.listener_snoop_criteria_select ?
                       ext_hit : basic_hit;
   // group membership snooping on ipv4
   wire igmp_fwd = ctrl.group_snoop_enable & info.is_ipv4 &
                   info.is_igmp; // R12
   // listener discovery snooping on ipv6
   wire mld_fwd = ctrl.listener_snoop_enable & info.is_ipv6 &
                  listener_pkt; // R13

   assign to_host = igmp_fwd | mld_fwd;
   // and-mode needs both ports, or-mode either port
   assign mirror = ctrl.mirror_and_mode ?
                   (info.src_match & info.dst_match) : // R16
                   (info.src_match | info.dst_match); // R17
endmodule // snoop_mirror_filter

/* tb.sv */
`timescale 1ns/10ps
// ****************************************************************
// bench for the dscp priority map and snoop/mirror control
// ****************************************************************
module tb;
   logic core_clk = 1'h0; // 50 MHz clock
   logic sys_rst = 1'h1; // async reset, held at start
   logic reg_wr_en = 1'h0; // register write request
   logic reg_rd_en = 1'h0; // register read request
   logic [15:0] reg_addr = 16'h0000; // register byte address
   logic [7:0] reg_wdata = 8'h00; // write data
   logic [7:0] reg_rdata_ff; // read data from the block
   logic reg_ack_ff; // access acknowledge
   logic frame_valid = 1'h0; // frame facts valid
   dscp_snoop_pkg::frame_info_type frame_info = '0; // frame facts
   logic verdict_valid_ff; // verdict valid
   dscp_snoop_pkg::verdict_type verdict_ff; // verdict from the block
   dscp_snoop_pkg::verdict_type got; // verdict captured by send
   logic [7:0] rd; // data captured by an access
   logic [7:0] v; // expected register value
   logic [2:0] e; // expected priority
   int n_mismatch = 0; // mismatches seen
   int compares = 0; // comparisons made
   // own copy of the map offsets, index k serves codes 0x2A+2k
   logic [15:0] map_addr [11] = '{16'h0355, 16'h0350, 16'h0357,
      16'h0358, 16'h0359, 16'h035A, 16'h035B, 16'h035C, 16'h035D,
      16'h035E, 16'h035F};

   // ****************************************************************
   // clock and block under test
   // ****************************************************************
   // free running clock, 20 ns period
   always #10 core_clk = ~core_clk;

   dscp_priority_and_snoop_ctrl i_dscp_priority_and_snoop_ctrl
   (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata_ff(reg_rdata_ff),
      .reg_ack_ff(reg_ack_ff),
      .frame_valid(frame_valid),
      .frame_info(frame_info),
      .verdict_valid_ff(verdict_valid_ff),
      .verdict_ff(verdict_ff)
   );

   // ****************************************************************
   // helpers
   // ****************************************************************
   // compare one value, count and report
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t seen %h expected %h",
            $time, seen, exp);
      end
   endtask

   // one register access, request held over one rising edge
   task automatic reg_access(input logic wr, input logic [15:0] addr,
      input logic [7:0] wdata);
      @(negedge core_clk);
      reg_wr_en = wr;
      reg_rd_en = !wr;
      reg_addr = addr;
      reg_wdata = wdata;
      @(negedge core_clk);
      check({7'h00, reg_ack_ff}, 8'h01);
      rd = reg_rdata_ff;
      reg_wr_en = 1'h0;
      reg_rd_en = 1'h0;
   endtask

   // write a register
   task automatic reg_write(input logic [15:0] addr,
      input logic [7:0] wdata);
      reg_access(1'h1, addr, wdata);
   endtask

   // read a register and compare
   task automatic reg_read(input logic [15:0] addr,
      input logic [7:0] exp);
      reg_access(1'h0, addr, 8'h00);
      check(rd, exp);
   endtask

   // offer one frame and capture the verdict a cycle later
   task automatic send(input logic v4, input logic v6, input logic igmp,
      input logic [5:0] dscp, input logic [7:0] nh,
      input logic [7:0] hnh, input logic s, input logic d);
      @(negedge core_clk);
      frame_valid = 1'h1;
      frame_info = '{v4, v6, igmp, dscp, nh, hnh, s, d};
      @(negedge core_clk);
      check({7'h00, verdict_valid_ff}, 8'h01);
      got = verdict_ff;
      frame_valid = 1'h0;
   endtask

   // ipv6 frame, compare the host forwarding flag
   task automatic mld(input logic [7:0] nh, input logic [7:0] hnh,
      input logic exp);
      send(1'h0, 1'h1, 1'h0, 6'h00, nh, hnh, 1'h0, 1'h0);
      check({7'h00, got.to_host}, {7'h00, exp});
   endtask

   // ipv4 group membership frame, compare the host forwarding flag
   task automatic igmp(input logic exp);
      send(1'h1, 1'h0, 1'h1, 6'h00, 8'h02, 8'h00, 1'h0, 1'h0);
      check({7'h00, got.to_host}, {7'h00, exp});
   endtask

   // map value per register, repeating every eight registers, reserved bits set
   function automatic logic [7:0] map_val(input int k);
      return {1'h1, 3'((k + 3) % 8), 1'h1, 3'(k % 8)};
   endfunction

   // verdict and end of run
   task automatic test_done();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ****************************************************************
   // watchdog
   // ****************************************************************
   // cuts a hang short well after the expected run length
   initial
   begin
      #400000;
      n_mismatch++;
      test_done();
   end

   // ****************************************************************
   // test sequence
   // ****************************************************************
   initial
   begin
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      sys_rst = 1'h0;
      // reset values of every register
      for (int k = 0; k < 11; k++)
         reg_read(map_addr[k], 8'h00);
      reg_read(dscp_snoop_pkg::CTRL_ADDR, 8'h00);
      // default map gives priority zero
      send(1'h1, 1'h0, 1'h0, 6'h2B, 8'h00, 8'h00, 1'h0, 1'h0);
      check({7'h00, got.prio_hit}, 8'h01);
      check({5'h00, got.prio}, 8'h00);
      // program every map, reserved bits must be dropped
      for (int k = 0; k < 11; k++)
         reg_write(map_addr[k], map_val(k));
      for (int k = 0; k < 11; k++)
         reg_read(map_addr[k], map_val(k) & 8'h77);
      // every mapped code, ipv4 and ipv6 alternately by pair of codes
      for (int c = 16'h2A; c <= 16'h3F; c++)
      begin
         v = map_val((c - 16'h2A) / 2);
         e = c[0] ? v[6:4] : v[2:0];
         send(c[1], !c[1], 1'h0, 6'(c), 8'h00, 8'h00, 1'h0, 1'h0);
         check({7'h00, got.prio_hit}, 8'h01);
         check({5'h00, got.prio}, {5'h00, e});
      end
      // code below the range and a non-ip frame get no mapping
      send(1'h1, 1'h0, 1'h0, 6'h29, 8'h00, 8'h00, 1'h0, 1'h0);
      check({7'h00, got.prio_hit}, 8'h00);
      send(1'h0, 1'h0, 1'h0, 6'h2A, 8'h00, 8'h00, 1'h0, 1'h0);
      check({7'h00, got.prio_hit}, 8'h00);
      // unmapped place: write ignored, reads zero, maps untouched
      reg_write(16'h0356, 8'hFF);
      reg_read(16'h0356, 8'h00);
      reg_read(16'h0350, map_val(1) & 8'h77);
      // write then read back to back on one mapping register
      @(negedge core_clk);
      reg_wr_en = 1'h1;
      reg_addr = map_addr[5];
      reg_wdata = 8'hA5;
      @(negedge core_clk);
      reg_wr_en = 1'h0;
      reg_rd_en = 1'h1;
      @(negedge core_clk);
      check(reg_rdata_ff, 8'h25);
      check({7'h00, reg_ack_ff}, 8'h01);
      reg_rd_en = 1'h0;
      // control register keeps only its four bits
      reg_write(dscp_snoop_pkg::CTRL_ADDR, 8'hFF);
      reg_read(dscp_snoop_pkg::CTRL_ADDR, 8'h4D);
      // group snooping on, listener off
      reg_write(dscp_snoop_pkg::CTRL_ADDR, 8'h40);
      igmp(1'h1);
      mld(8'h3A, 8'h00, 1'h0);
      // listener on, group off, default criteria
      reg_write(dscp_snoop_pkg::CTRL_ADDR, 8'h04);
      igmp(1'h0);
      mld(8'h01, 8'h00, 1'h1);
      mld(8'h3A, 8'h00, 1'h1);
      mld(8'h00, 8'h01, 1'h1);
      mld(8'h00, 8'h3A, 1'h1);
      mld(8'h2B, 8'h00, 1'h0);
      mld(8'h00, 8'h3C, 1'h0);
      // alternate criteria
      reg_write(dscp_snoop_pkg::CTRL_ADDR, 8'h0C);
      foreach (map_addr[k])
      begin
         v = (k == 0) ? 8'h2B : (k == 1) ? 8'h2C : (k == 2) ? 8'h32
            : (k == 3) ? 8'h33 : 8'h3C;
         mld(v, 8'h00, 1'h1);
         mld(8'h00, v, 1'h1);
      end
      mld(8'h3A, 8'h00, 1'h0);
      mld(8'h00, 8'h01, 1'h0);
      // criteria set but listener snooping off
      reg_write(dscp_snoop_pkg::CTRL_ADDR, 8'h08);
      mld(8'h2B, 8'h00, 1'h0);
      // mirror filter, and-mode then or-mode, all match pairs
      for (int m = 1; m >= 0; m--)
      begin
         reg_write(dscp_snoop_pkg::CTRL_ADDR, {7'h00, 1'(m)});
         for (int j = 0; j < 4; j++)
         begin
            send(1'h1, 1'h0, 1'h0, 6'h00, 8'h00, 8'h00, j[1], j[0]);
            e = {2'h0, m ? (j[1] & j[0]) : (j[1] | j[0])};
            check({7'h00, got.mirror}, {5'h00, e});
         end
      end
      // second reset in mid-run clears outputs and registers
      @(negedge core_clk);
      sys_rst = 1'h1;
      @(negedge core_clk);
      check({2'h0, verdict_ff}, 8'h00);
      check(reg_rdata_ff, 8'h00);
      sys_rst = 1'h0;
      reg_read(map_addr[0], 8'h00);
      reg_read(dscp_snoop_pkg::CTRL_ADDR, 8'h00);
      test_done();
   end
endmodule // tb
